// *** core/dmps_pkg.sv ***
// Purpose: Shared constants for the synthesizer control block
// Assumes: Register words are 24 bits wide, indexed 1 to 5
// Notes: Field positions follow the control word layout
package dmps_pkg;
    localparam int DMPS_ADDR_W = 3;
    localparam int DMPS_DATA_W = 24;
    // Register indexes
    localparam logic [2:0] DMPS_REG_TX = 3'h1;
    localparam logic [2:0] DMPS_REG_RX = 3'h2;
    localparam logic [2:0] DMPS_REG_LO2 = 3'h3;
    localparam logic [2:0] DMPS_REG_REF = 3'h4;
    localparam logic [2:0] DMPS_REG_STAT = 3'h5;
    // Field positions in registers 1 and 2
    localparam int DMPS_SWAL_LSB = 0;
    localparam int DMPS_SWAL_W = 7;
    localparam int DMPS_MAIN_LSB = 7;
    localparam int DMPS_MAIN_W = 13;
    localparam int DMPS_GAIN_BIT = 20;
    localparam int DMPS_POL_BIT = 21;
    // Fields of register 3
    localparam int DMPS_LO2_LSB = 0;
    localparam int DMPS_LO2_W = 14;
    localparam int DMPS_LO2_GAIN_BIT = 14;
    localparam int DMPS_LO2_POL_BIT = 15;
    localparam int DMPS_MODV_BIT = 16;
    // Fields of register 4
    localparam int DMPS_REF_LSB = 0;
    localparam int DMPS_REF_W = 12;
    localparam int DMPS_CAP_LSB = 18;
    localparam int DMPS_CAP_W = 3;
    // Reset values
    localparam logic [23:0] DMPS_RST_WORD = 24'h000000;
    // Pump gain codes: low or four times higher
    localparam logic [2:0] DMPS_GAIN_LOW = 3'h1;
    localparam logic [2:0] DMPS_GAIN_HIGH = 3'h4;
endpackage : dmps_pkg

// *** core/dmps_sync.sv ***
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Input is a slow level relative to i_clk
// Notes: First stage feeds only the second
`timescale 1ns/10ps
module dmps_sync (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_async,
    output logic o_sync
);
    logic meta_reg;
    logic sync_reg;

    // Only sync_reg leaves this module
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule : dmps_sync

// *** core/dmps_pfd.sv ***
// Purpose: Phase frequency detector driving a three-state charge pump
// Assumes: Reference and feedback are one-cycle pulses on i_clk
// Notes: Polarity swaps up and down for inverting filter/VCO pairs
`timescale 1ns/10ps
module dmps_pfd
    import dmps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ref_pulse,
    input wire logic i_fb_pulse,
    input wire logic i_invert,
    input wire logic i_gain_high,
    output logic o_pump_up,
    output logic o_pump_down,
    output logic o_pump_up_oe_n,
    output logic o_pump_down_oe_n,
    output logic [2:0] o_pump_gain
);
    logic up_reg;
    logic dn_reg;
    logic up_next;
    logic dn_next;
    logic up_drv_reg;
    logic dn_drv_reg;
    logic [2:0] gain_reg;

    // An opposing pulse clears both, so up and down are never set together; clearing both returns to high-Z
    assign up_next = (up_reg | i_ref_pulse) & ~(dn_reg | i_fb_pulse);
    assign dn_next = (dn_reg | i_fb_pulse) & ~(up_reg | i_ref_pulse);

    // Pump state and polarity swap
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            up_reg <= 1'b0;
            dn_reg <= 1'b0;
            up_drv_reg <= 1'b0;
            dn_drv_reg <= 1'b0;
            gain_reg <= DMPS_GAIN_LOW;
        end else begin
            up_reg <= up_next;
            dn_reg <= dn_next;
            up_drv_reg <= i_invert ? dn_next : up_next;
            dn_drv_reg <= i_invert ? up_next : dn_next;
            gain_reg <= i_gain_high ? DMPS_GAIN_HIGH : DMPS_GAIN_LOW;
        end
    end

    // Output drives only while pumping, else high impedance
    assign o_pump_up = up_drv_reg;
    assign o_pump_down = dn_drv_reg;
    assign o_pump_up_oe_n = ~up_drv_reg;
    assign o_pump_down_oe_n = ~dn_drv_reg;
    assign o_pump_gain = gain_reg;
endmodule : dmps_pfd

// *** core/dmps_synth.sv ***
// Purpose: Control and dividers of three frequency synthesizers
// Assumes: Prescaler outputs and reference are slow against i_clk
// Notes: Dividers count synchronised edges of the pin inputs
`timescale 1ns/10ps
module dmps_synth
    import dmps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [dmps_pkg::DMPS_ADDR_W-1:0] i_addr,
    input wire logic [dmps_pkg::DMPS_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [dmps_pkg::DMPS_DATA_W-1:0] o_rdata,
    input wire logic i_ref_osc,
    input wire logic [1:0] i_presc,
    input wire logic i_lo2_vco,
    output logic [1:0] o_modulus,
    output logic o_modulus_voltage,
    output logic [1:0] o_pump_up,
    output logic [1:0] o_pump_down,
    output logic [1:0] o_pump_up_oe_n,
    output logic [1:0] o_pump_down_oe_n,
    output logic [5:0] o_pump_gain,
    output logic o_lo2_pump_up,
    output logic o_lo2_pump_down,
    output logic o_lo2_pump_up_oe_n,
    output logic o_lo2_pump_down_oe_n,
    output logic [2:0] o_lo2_pump_gain,
    output logic [2:0] o_tank_cap_sel
);
    import dmps_pkg::*;

    logic [23:0] reg_tx_reg;
    logic [23:0] reg_rx_reg;
    logic [23:0] reg_lo2_reg;
    logic [23:0] reg_ref_reg;
    logic [23:0] rdata_reg;
    logic [23:0] rdata_next;
    logic [23:0] loop_word [2];
    logic ref_sync;
    logic ref_d_reg;
    logic ref_edge;
    logic [DMPS_REF_W-1:0] ref_cnt_reg;
    logic ref_pulse_reg;
    logic [1:0] presc_sync;
    logic [1:0] fb_pulse;
    logic [1:0] lock_seen_reg;
    logic [1:0] fb_end;
    logic [DMPS_REF_W-1:0] ref_load;
    logic ref_done;
    logic [DMPS_LO2_W-1:0] lo2_load;
    logic lo2_done;
    logic lo2_invert;
    logic lo2_gain_high;
    logic modv_bit;
    logic [DMPS_CAP_W-1:0] cap_code;
    logic [2:0] stat_word;
    logic lo2_sync;
    logic lo2_d_reg;
    logic lo2_edge;
    logic [DMPS_LO2_W-1:0] lo2_cnt_reg;
    logic lo2_fb_reg;
    logic sel_tx;
    logic sel_rx;
    logic sel_lo2;
    logic sel_ref;
    logic sel_stat;

    // Address decode for the plain register port
    assign sel_tx = (i_addr == DMPS_REG_TX);
    assign sel_rx = (i_addr == DMPS_REG_RX);
    assign sel_lo2 = (i_addr == DMPS_REG_LO2);
    assign sel_ref = (i_addr == DMPS_REG_REF);
    assign sel_stat = (i_addr == DMPS_REG_STAT);

    // Field taps; every field is read through one named wire
    assign ref_load = reg_ref_reg[DMPS_REF_LSB +: DMPS_REF_W];
    assign lo2_load = reg_lo2_reg[DMPS_LO2_LSB +: DMPS_LO2_W];
    assign lo2_invert = reg_lo2_reg[DMPS_LO2_POL_BIT];
    assign lo2_gain_high = reg_lo2_reg[DMPS_LO2_GAIN_BIT];
    assign modv_bit = reg_lo2_reg[DMPS_MODV_BIT];
    assign cap_code = reg_ref_reg[DMPS_CAP_LSB +: DMPS_CAP_W];

    // Status bits: feedback seen per loop, second loop pulse
    assign stat_word = {lo2_fb_reg, lock_seen_reg};

    // Terminal counts; loads of 0 or 1 divide by one
    assign ref_done = (ref_cnt_reg <= 12'h001);
    assign lo2_done = (lo2_cnt_reg <= 14'h0001);

    // Configuration registers, written in one cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            reg_tx_reg <= DMPS_RST_WORD;
            reg_rx_reg <= DMPS_RST_WORD;
            reg_lo2_reg <= DMPS_RST_WORD;
            reg_ref_reg <= DMPS_RST_WORD;
        end else if (i_wr) begin
            if (sel_tx) reg_tx_reg <= i_wdata;
            if (sel_rx) reg_rx_reg <= i_wdata;
            if (sel_lo2) reg_lo2_reg <= i_wdata;
            if (sel_ref) reg_ref_reg <= i_wdata;
        end
    end

    // Read mux; unmapped addresses read zero
    assign rdata_next = sel_tx ? reg_tx_reg :
                        sel_rx ? reg_rx_reg :
                        sel_lo2 ? reg_lo2_reg :
                        sel_ref ? reg_ref_reg :
                        sel_stat ? {21'h000000, stat_word} :
                        24'h000000;

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdata_reg <= 24'h000000;
        end else begin
            rdata_reg <= i_rd ? rdata_next : 24'h000000;
        end
    end

    assign o_rdata = rdata_reg;

    // Reference oscillator enters through a synchroniser
    dmps_sync u_ref_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async(i_ref_osc),
        .o_sync(ref_sync)
    );

    assign ref_edge = ref_sync & ~ref_d_reg;

    // Edge detector state; resets to the pin's idle low level
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ref_d_reg <= 1'b0;
        end else begin
            ref_d_reg <= ref_sync;
        end
    end

    // Shared reference divider; count zero behaves as divide by one
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ref_cnt_reg <= 12'h000;
            ref_pulse_reg <= 1'b0;
        end else begin
            ref_pulse_reg <= 1'b0;
            if (ref_edge) begin
                if (ref_done) begin
                    ref_cnt_reg <= ref_load;
                    ref_pulse_reg <= 1'b1;
                end else begin
                    ref_cnt_reg <= ref_cnt_reg - 12'h001;
                end
            end
        end
    end

    // Per-loop word view so the generate body stays uniform
    assign loop_word[0] = reg_tx_reg;
    assign loop_word[1] = reg_rx_reg;

    // Each loop counts prescaler edges three clocks after the pin moves.
    // The modulus level therefore changes a few clocks after the edge
    // that ends the swallow phase; the prescaler takes its ratio at the
    // start of its next output period, which the slow pin allows.
    // Hazard: a swallow value at or above the main value keeps the
    // larger ratio for the whole cycle, so software keeps it below.
    // Two identical, independent dual-modulus loops
    for (genvar g = 0; g < 2; g++) begin : g_loop
        logic [DMPS_MAIN_W-1:0] main_cnt_reg;
        logic [DMPS_SWAL_W-1:0] swal_cnt_reg;
        logic mod_high_reg;
        logic main_done;
        logic swal_last;
        logic presc_d_reg;
        logic lock_reg;
        logic loop_invert;
        logic loop_gain_high;
        logic [DMPS_MAIN_W-1:0] main_load;
        logic [DMPS_SWAL_W-1:0] swal_load;

        // Field taps of this loop's word
        assign main_load = loop_word[g][DMPS_MAIN_LSB +: DMPS_MAIN_W];
        assign swal_load = loop_word[g][DMPS_SWAL_LSB +: DMPS_SWAL_W];
        assign loop_invert = loop_word[g][DMPS_POL_BIT];
        assign loop_gain_high = loop_word[g][DMPS_GAIN_BIT];

        dmps_sync u_presc_sync (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_async(i_presc[g]),
            .o_sync(presc_sync[g])
        );

        // Edge detector state of the prescaler pin
        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                presc_d_reg <= 1'b0;
            end else begin
                presc_d_reg <= presc_sync[g];
            end
        end

        assign fb_pulse[g] = presc_sync[g] & ~presc_d_reg;
        assign main_done = (main_cnt_reg <= 13'h0001);
        assign swal_last = (swal_cnt_reg <= 7'h01);
        // One pulse per full main cycle goes to the phase detector
        assign fb_end[g] = fb_pulse[g] & main_done;

        // Main divider with swallow counter
        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                main_cnt_reg <= 13'h0000;
                swal_cnt_reg <= 7'h00;
                mod_high_reg <= 1'b0;
            end else begin
                if (fb_pulse[g]) begin
                    if (main_done) begin
                        // Reload both counters each cycle
                        main_cnt_reg <= main_load;
                        swal_cnt_reg <= swal_load;
                        mod_high_reg <= (swal_load != 7'h00);
                    end else begin
                        main_cnt_reg <= main_cnt_reg - 13'h0001;
                        if (swal_last) begin
                            swal_cnt_reg <= 7'h00;
                            mod_high_reg <= 1'b0;
                        end else begin
                            swal_cnt_reg <= swal_cnt_reg - 7'h01;
                        end
                    end
                end
            end
        end

        assign o_modulus[g] = mod_high_reg;

        // Lock indicator: set by the first end-of-cycle feedback pulse, held until reset
        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                lock_reg <= 1'b0;
            end else if (fb_end[g]) begin
                lock_reg <= 1'b1;
            end
        end

        assign lock_seen_reg[g] = lock_reg;

        dmps_pfd u_pfd (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_ref_pulse(ref_pulse_reg),
            .i_fb_pulse(fb_end[g]),
            .i_invert(loop_invert),
            .i_gain_high(loop_gain_high),
            .o_pump_up(o_pump_up[g]),
            .o_pump_down(o_pump_down[g]),
            .o_pump_up_oe_n(o_pump_up_oe_n[g]),
            .o_pump_down_oe_n(o_pump_down_oe_n[g]),
            .o_pump_gain(o_pump_gain[g*3 +: 3])
        );
    end

    // Common drive mode of both modulus outputs
    assign o_modulus_voltage = modv_bit;

    // Second local oscillator feedback
    dmps_sync u_lo2_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async(i_lo2_vco),
        .o_sync(lo2_sync)
    );

    assign lo2_edge = lo2_sync & ~lo2_d_reg;

    // Edge detector state of the second oscillator pin
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            lo2_d_reg <= 1'b0;
        end else begin
            lo2_d_reg <= lo2_sync;
        end
    end

    // 14-bit divider of the second loop
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            lo2_cnt_reg <= 14'h0000;
            lo2_fb_reg <= 1'b0;
        end else begin
            lo2_fb_reg <= 1'b0;
            if (lo2_edge) begin
                if (lo2_done) begin
                    lo2_cnt_reg <= lo2_load;
                    lo2_fb_reg <= 1'b1;
                end else begin
                    lo2_cnt_reg <= lo2_cnt_reg - 14'h0001;
                end
            end
        end
    end

    // Polarity left to software; oscillator is non-inverting,
    // so a set bit here drives the loop away from lock
    dmps_pfd u_lo2_pfd (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ref_pulse(ref_pulse_reg),
        .i_fb_pulse(lo2_fb_reg),
        .i_invert(lo2_invert),
        .i_gain_high(lo2_gain_high),
        .o_pump_up(o_lo2_pump_up),
        .o_pump_down(o_lo2_pump_down),
        .o_pump_up_oe_n(o_lo2_pump_up_oe_n),
        .o_pump_down_oe_n(o_lo2_pump_down_oe_n),
        .o_pump_gain(o_lo2_pump_gain)
    );

    // Tank capacitor code, about 1.1 pF per step
    // Code 0 leaves the tank capacitor out
    assign o_tank_cap_sel = cap_code;
endmodule : dmps_synth

// *** testbench/dmps_synth_properties.sv ***
// Purpose: Port checks of the synthesizer control block
// Assumes: Shadow words follow the register writes
// Notes: Status word at index 5 is not modelled
`timescale 1ns/10ps
module dmps_synth_props
    import dmps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [dmps_pkg::DMPS_ADDR_W-1:0] i_addr,
    input wire logic [dmps_pkg::DMPS_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [dmps_pkg::DMPS_DATA_W-1:0] o_rdata,
    input wire logic [1:0] o_modulus,
    input wire logic o_modulus_voltage,
    input wire logic [1:0] o_pump_up,
    input wire logic [1:0] o_pump_up_oe_n,
    input wire logic [5:0] o_pump_gain,
    input wire logic [2:0] o_lo2_pump_gain,
    input wire logic [2:0] o_tank_cap_sel
);
    logic [23:0] sh [1:4];
    logic [23:0] exp_rd;
    wire in_map = i_addr >= 3'h1 && i_addr <= 3'h4;
    function automatic logic [2:0] gc(input logic b);
        return b ? DMPS_GAIN_HIGH : DMPS_GAIN_LOW;
    endfunction : gc
    // Shadow words; unmapped and read-only writes dropped
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sh <= '{default: 24'h0};
        end else if (i_wr && in_map) begin
            sh[i_addr] <= i_wdata;
        end
    end
    assign exp_rd = in_map ? sh[i_addr] : 24'h0;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    rst_state_a: assert property ($past(i_reset) |->
        o_modulus == 2'h0 && o_pump_up_oe_n == 2'h3)
        else $error("outputs not idle after reset");
    rd_idle_a: assert property (!i_rd |=> o_rdata == 24'h0)
        else $error("read data outside read slot");
    rd_data_a: assert property (
        i_rd && i_addr != DMPS_REG_STAT |=> o_rdata == $past(exp_rd))
        else $error("read data wrong");
    mod_drive_a: assert property (
        i_wr && i_addr == DMPS_REG_LO2 |=>
        o_modulus_voltage == $past(i_wdata[16]))
        else $error("modulus drive mode wrong");
    cap_sel_a: assert property (
        i_wr && i_addr == DMPS_REG_REF |=>
        o_tank_cap_sel == $past(i_wdata[20:18]))
        else $error("tank select wrong");
    cap_hold_a: assert property (
        !(i_wr && i_addr == DMPS_REG_REF) |=> $stable(o_tank_cap_sel))
        else $error("tank select moved");
    pump_gain_a: assert property (
        !$past(i_wr) && !$past(i_wr, 2) |->
        o_pump_gain == {gc(sh[2][20]), gc(sh[1][20])})
        else $error("loop pump gain wrong");
    lo2_gain_a: assert property (
        !$past(i_wr) && !$past(i_wr, 2) |->
        o_lo2_pump_gain == gc(sh[3][14]))
        else $error("second loop pump gain wrong");
    cover property (i_rd && i_addr == DMPS_REG_TX);
    cover property ($rose(o_modulus[0]));
    cover property (o_pump_up[0] && !o_pump_up_oe_n[0]);
endmodule : dmps_synth_props
bind dmps_synth dmps_synth_props dmps_synth_props_inst (.*);

// *** testbench/dmps_presc_model.sv ***
// Purpose: Dual modulus prescaler fed by a free VCO
// Assumes: VCO period scaled to 5 ns
// Notes: Ratio is taken at each output period start
`timescale 1ns/10ps
module dmps_presc_model #(
    parameter int P = 64
) (
    input wire logic i_mod,
    output logic o_div
);
    int n;
    // Unknown control counts as the small ratio
    initial begin
        o_div = 1'b0;
        forever begin
            n = (i_mod === 1'b1) ? P + 1 : P;
            #(2.5 * n) o_div = 1'b1;
            #(2.5 * n) o_div = 1'b0;
        end
    end
endmodule : dmps_presc_model

// *** testbench/dmps_synth_tb_top.sv ***
// Purpose: Self-checking bench of the synthesizer block
// Assumes: Oscillator 200 ns, loop reference divide by 3
// Notes: Feedback pins come from prescaler models
`timescale 1ns/10ps
module dmps_synth_tb_top;
    import dmps_pkg::*;
    logic i_clk, i_reset, i_wr, i_rd, i_ref_osc;
    logic [2:0] i_addr, o_lo2_pump_gain, o_tank_cap_sel;
    logic [23:0] i_wdata, o_rdata;
    wire [1:0] i_presc;
    wire i_lo2_vco;
    logic [1:0] o_modulus, o_pump_up, o_pump_down;
    logic [1:0] o_pump_up_oe_n, o_pump_down_oe_n;
    logic o_modulus_voltage, o_lo2_pump_up, o_lo2_pump_down;
    logic o_lo2_pump_up_oe_n, o_lo2_pump_down_oe_n;
    logic [5:0] o_pump_gain;
    logic [2:0] up_on, dn_on;
    int n_fail, check_count;
    dmps_synth dmps_synth_inst (.*);
    dmps_presc_model tx_pre (.i_mod(o_modulus[0]), .o_div(i_presc[0]));
    dmps_presc_model rx_pre (.i_mod(o_modulus[1]), .o_div(i_presc[1]));
    dmps_presc_model lo2_osc (.i_mod(1'b0), .o_div(i_lo2_vco));
    // Drive counts only while the pump pin is enabled
    assign up_on = {o_lo2_pump_up & ~o_lo2_pump_up_oe_n,
        o_pump_up & ~o_pump_up_oe_n};
    assign dn_on = {o_lo2_pump_down & ~o_lo2_pump_down_oe_n,
        o_pump_down & ~o_pump_down_oe_n};
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        i_ref_osc = 1'b0;
        forever #100 i_ref_osc = ~i_ref_osc;
    end
    task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task chk_gt(input string nm, input int a, input int b);
        check_count++;
        if (!(a > b)) begin
            n_fail++;
            $display("[FAIL] %s expected above %0d seen %0d", nm, b, a);
        end
    endtask : chk_gt
    task wr(input logic [2:0] a, input logic [23:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask : wr
    task rd(input logic [2:0] a, output logic [23:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd
    // Quotient and remainder by the small prescaler ratio
    task set_loop(input logic [2:0] a, input int nt, input logic pol);
        wr(a, {2'h0, pol, 1'b0, 13'(nt / 64), 7'(nt % 64)});
    endtask : set_loop
    // Mid-run reset: counts loaded from earlier words must not linger
    task do_reset;
        @(posedge i_clk);
        i_reset <= 1'b1;
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        #1;
        chk("gain after reset", 24'h9, {18'h0, o_pump_gain});
    endtask : do_reset
    // Prescaler rising edges while modulus holds level v
    task edges(input int b, input logic v, output int n);
        logic pv;
        n = 0;
        pv = i_presc[b];
        for (int k = 0; k < 400 && o_modulus[b] === v; k++) begin
            @(posedge i_clk);
            #1;
            n += (i_presc[b] && !pv);
            pv = i_presc[b];
        end
    endtask : edges
    task pump(input int b, output int u, output int d);
        u = 0;
        d = 0;
        repeat (100) @(posedge i_clk);
        repeat (400) begin
            @(posedge i_clk);
            #1;
            u += up_on[b];
            d += dn_on[b];
        end
    endtask : pump
    task t_reset;
        logic [23:0] d;
        chk("gain", 24'h9, {18'h0, o_pump_gain});
        chk("lo2 gain", 24'h1, {21'h0, o_lo2_pump_gain});
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], d);
            if (a != 5) chk("word", 24'h0, d);
        end
    endtask : t_reset
    task t_regs;
        logic [23:0] p [1:4];
        logic [23:0] d;
        p = '{24'h2a5a5a, 24'h15a5a5, 24'h015a5a, 24'h1c0abc};
        for (int a = 1; a < 5; a++) wr(a[2:0], p[a]);
        wr(3'h6, 24'hffffff);
        for (int a = 1; a < 7; a++) begin
            rd(a[2:0], d);
            if (a != 5) chk("readback", a < 5 ? p[a] : 24'h0, d);
        end
        chk("gains", 24'h21, {18'h0, o_pump_gain});
        chk("lo2 gain", 24'h4, {21'h0, o_lo2_pump_gain});
        chk("drive", 24'h1, {23'h0, o_modulus_voltage});
    endtask : t_regs
    task t_cap;
        for (int c = 0; c < 8; c++) begin
            wr(3'h4, {3'h0, c[2:0], 18'h3});
            chk("tank", {21'h0, c[2:0]}, {21'h0, o_tank_cap_sel});
        end
    endtask : t_cap
    task t_mod;
        int hi, lo;
        logic [23:0] st;
        do_reset;
        wr(3'h4, 24'h3);
        set_loop(3'h1, 322, 1'b0);
        set_loop(3'h2, 257, 1'b0);
        for (int b = 0; b < 2; b++) begin
            edges(b, 1'b1, hi);
            edges(b, 1'b0, lo);
            edges(b, 1'b1, hi);
            edges(b, 1'b0, lo);
            chk("high edges", 24'(2 - b), 24'(hi));
            chk("low edges", 24'h3, 24'(lo));
        end
        rd(3'h5, st);
        chk("feedback seen", 24'h3, st & 24'h3);
    endtask : t_mod
    // Slow feedback asks for up; a divide by one gives fast feedback
    task t_pump;
        int u, d;
        for (int i = 0; i < 3; i++) begin
            set_loop(3'h1, 322, i == 1);
            wr(3'h3, {8'h0, i == 1, 1'b0, (i == 2) ? 14'h1 : 14'h8});
            pump(0, u, d);
            if (i == 1) chk_gt("tx down", d, u);
            else chk_gt("tx up", u, d);
            pump(2, u, d);
            if (i == 0) chk_gt("lo2 up", u, d);
            else chk_gt("lo2 down", d, u);
        end
    endtask : t_pump
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    initial begin
        i_reset = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 3'h0;
        i_wdata = 24'h0;
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        #1;
        t_reset;
        t_regs;
        t_cap;
        t_mod;
        t_pump;
        end_of_test;
    end
    // Whole run needs about 3200 cycles
    initial begin
        #300000;
        n_fail++;
        end_of_test;
    end
endmodule : dmps_synth_tb_top
